// >>> logic/sbc_params.svh
// constants for the sdram bank command state machine
`ifndef SBC_PARAMS_SVH
`define SBC_PARAMS_SVH

`define SBC_CLK_MHZ       250
`define SBC_MHZ_NS_SCALE  1000
`define SBC_ADDR_W        10
`define SBC_COL_W         8
`define SBC_BANK_BIT      9
`define SBC_AP_BIT        8
`define SBC_TIMER_W       8

`define SBC_PIN_W         15
`define SBC_PIN_CKE       14
`define SBC_PIN_CS        13
`define SBC_PIN_CMD_HI    12
`define SBC_PIN_CMD_LO    10
`define SBC_PIN_RST       15'h3C00

`define SBC_CMD_MRS       3'h0
`define SBC_CMD_REF       3'h1
`define SBC_CMD_PRE       3'h2
`define SBC_CMD_ACT       3'h3
`define SBC_CMD_WRITE     3'h4
`define SBC_CMD_READ      3'h5
`define SBC_CMD_BST       3'h6
`define SBC_CMD_NOP       3'h7

`define SBC_BL_1          3'h0
`define SBC_BL_2          3'h1
`define SBC_BL_4          3'h2
`define SBC_BL_8          3'h3
`define SBC_BL_PAGE       3'h7
`define SBC_MASK_1        8'h00
`define SBC_MASK_2        8'h01
`define SBC_MASK_4        8'h03
`define SBC_MASK_8        8'h07
`define SBC_MASK_PAGE     8'hFF

`define SBC_T_RP_NS       24
`define SBC_T_WR_NS       16
`define SBC_T_RP_CYC      ((`SBC_T_RP_NS * `SBC_CLK_MHZ + `SBC_MHZ_NS_SCALE - 1) / `SBC_MHZ_NS_SCALE)
`define SBC_T_WR_CYC      ((`SBC_T_WR_NS * `SBC_CLK_MHZ + `SBC_MHZ_NS_SCALE - 1) / `SBC_MHZ_NS_SCALE)

`endif

// >>> logic/sbc_pkg.sv
// types for the sdram bank command state machine
package sbc_pkg;
  typedef enum logic [8:0] {
    SBC_IDLE     = 9'h001,
    SBC_ACTIVE   = 9'h002,
    SBC_READ     = 9'h004,
    SBC_WRITE    = 9'h008,
    SBC_READ_AP  = 9'h010,
    SBC_WRITE_AP = 9'h020,
    SBC_WR_RECOV = 9'h040,
    SBC_PRECHG   = 9'h080,
    SBC_PDOWN    = 9'h100
  } sbc_state_e;
  typedef logic [2:0] sbc_cmd_t;
endpackage

// >>> logic/sbc_burst_ctr.sv
// burst beat counter with column advance inside the burst boundary
`timescale 1ns/1ps
`include "sbc_params.svh"
module sbc_burst_ctr (
  input  wire logic                  clk_sys_i,
  input  wire logic                  rst_i,
  input  wire logic                  en_i,
  input  wire logic                  load_i,
  input  wire logic                  stop_i,
  input  wire logic [`SBC_COL_W-1:0] col_i,
  input  wire logic [2:0]            len_code_i,
  output logic                       active_o,
  output logic                       last_o,
  output logic [`SBC_COL_W-1:0]      col_o
);
  logic [`SBC_COL_W-1:0] mask;
  logic [`SBC_COL_W-1:0] mask_q;
  logic [`SBC_COL_W-1:0] rem_q;
  logic [`SBC_COL_W-1:0] col_inc;

  assign mask = (len_code_i == `SBC_BL_2)    ? `SBC_MASK_2 :
                (len_code_i == `SBC_BL_4)    ? `SBC_MASK_4 :
                (len_code_i == `SBC_BL_8)    ? `SBC_MASK_8 :
                (len_code_i == `SBC_BL_PAGE) ? `SBC_MASK_PAGE : `SBC_MASK_1;
  assign col_inc = (col_o & ~mask_q) | ((col_o + 8'h01) & mask_q);
  assign last_o  = active_o && (rem_q == 8'h00);

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      active_o <= 1'b0;
      rem_q    <= 8'h00;
      mask_q   <= 8'h00;
      col_o    <= 8'h00;
    end else if (load_i) begin
      active_o <= 1'b1;
      rem_q    <= mask;
      mask_q   <= mask;
      col_o    <= col_i;
    end else if (stop_i || (en_i && last_o)) begin
      active_o <= 1'b0;
    end else if (en_i && active_o) begin
      rem_q    <= rem_q - 8'h01;
      col_o    <= col_inc;
    end
  end
endmodule

// >>> logic/sbc_bank_fsm.sv
// per-bank command state machine of a two-bank synchronous dram
`timescale 1ns/1ps
`include "sbc_params.svh"
module sbc_bank_fsm #(
  parameter logic BANK_INDEX = 1'h0
) (
  input  wire logic                   clk_sys_i,
  input  wire logic                   rst_i,
  input  wire logic                   cke_i,
  input  wire logic                   cs_n_i,
  input  wire logic                   ras_n_i,
  input  wire logic                   cas_n_i,
  input  wire logic                   we_n_i,
  input  wire logic [`SBC_ADDR_W-1:0] addr_i,
  input  wire logic [2:0]             burst_len_i,
  input  wire logic                   cas_lat3_i,
  output sbc_pkg::sbc_state_e         state_o,
  output logic [`SBC_COL_W-1:0]       col_o,
  output logic                        rd_valid_o,
  output logic                        wr_accept_o,
  output logic                        precharge_o,
  output logic                        refresh_o,
  output logic                        mode_write_o,
  output logic                        illegal_o
);
  logic [`SBC_PIN_W-1:0]      pin_raw;
  logic [`SBC_PIN_W-1:0]      pin_s1_q;
  logic [`SBC_PIN_W-1:0]      pin_s2_q;
  logic                       cke_prev_q;
  sbc_pkg::sbc_state_e        state_q;
  sbc_pkg::sbc_state_e        state_d;
  logic                       illegal_d;
  logic                       ap_q;
  logic [`SBC_TIMER_W-1:0]    timer_q;
  logic [1:0]                 rd_pipe_q;
  logic                       ctr_active;
  logic                       ctr_last;

  assign pin_raw = {cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, addr_i};

  // decode of the synchronised command pins
  wire                        cke_now  = pin_s2_q[`SBC_PIN_CKE];
  wire                        en       = cke_prev_q;
  wire                        sel      = en && !pin_s2_q[`SBC_PIN_CS];
  wire sbc_pkg::sbc_cmd_t     cmd      = pin_s2_q[`SBC_PIN_CMD_HI:`SBC_PIN_CMD_LO];
  wire [`SBC_ADDR_W-1:0]      addr     = pin_s2_q[`SBC_ADDR_W-1:0];
  wire                        bank_hit = (addr[`SBC_BANK_BIT] == BANK_INDEX);
  wire                        ap_bit   = addr[`SBC_AP_BIT];
  wire                        quiet    = !sel || (cmd == `SBC_CMD_NOP);
  wire                        is_bst   = sel && (cmd == `SBC_CMD_BST);
  wire                        is_rd    = sel && (cmd == `SBC_CMD_READ);
  wire                        is_wr    = sel && (cmd == `SBC_CMD_WRITE);
  wire                        is_act   = sel && (cmd == `SBC_CMD_ACT) && bank_hit;
  wire                        is_ref   = sel && (cmd == `SBC_CMD_REF);
  wire                        is_mrs   = sel && (cmd == `SBC_CMD_MRS);
  wire                        pre_hit  = sel && (cmd == `SBC_CMD_PRE) && (ap_bit || bank_hit);
  wire                        rd_hit   = is_rd && bank_hit;
  wire                        wr_hit   = is_wr && bank_hit;
  wire                        rw_miss  = (is_rd || is_wr) && !bank_hit;
  wire                        bad_cmd  = is_act || is_ref || is_mrs;
  wire                        in_rd    = (state_q == sbc_pkg::SBC_READ) ||
                                         (state_q == sbc_pkg::SBC_READ_AP);
  wire                        in_wr    = (state_q == sbc_pkg::SBC_WRITE) ||
                                         (state_q == sbc_pkg::SBC_WRITE_AP);
  wire                        start_ok = (state_q == sbc_pkg::SBC_ACTIVE) ||
                                         (state_q == sbc_pkg::SBC_READ) ||
                                         (state_q == sbc_pkg::SBC_WRITE) ||
                                         ((state_q == sbc_pkg::SBC_WR_RECOV) && !ap_q);
  wire                        ctr_load = start_ok && (rd_hit || wr_hit);
  wire                        burst_nx = (state_d == sbc_pkg::SBC_READ) ||
                                         (state_d == sbc_pkg::SBC_WRITE) ||
                                         (state_d == sbc_pkg::SBC_READ_AP) ||
                                         (state_d == sbc_pkg::SBC_WRITE_AP);
  wire                        timer_done = (timer_q == 8'h00);
  wire                        rd_beat  = en && ctr_active && in_rd;
  wire                        pre_entry = (state_d == sbc_pkg::SBC_PRECHG) &&
                                          (state_q != sbc_pkg::SBC_PRECHG);
  wire sbc_pkg::sbc_state_e   rd_tgt   = ap_bit ? sbc_pkg::SBC_READ_AP : sbc_pkg::SBC_READ;
  wire sbc_pkg::sbc_state_e   wr_tgt   = ap_bit ? sbc_pkg::SBC_WRITE_AP : sbc_pkg::SBC_WRITE;

  always_comb begin
    state_d   = state_q;
    illegal_d = 1'b0;
    unique case (state_q)
      sbc_pkg::SBC_IDLE: begin
        if (en && !cke_now && (quiet || is_bst)) begin
          state_d = sbc_pkg::SBC_PDOWN;
        end else if (is_act) begin
          state_d = sbc_pkg::SBC_ACTIVE;
        end else if (rd_hit || wr_hit) begin
          illegal_d = 1'b1;
        end
      end
      sbc_pkg::SBC_ACTIVE: begin
        if (rd_hit) begin
          state_d = rd_tgt;
        end else if (wr_hit) begin
          state_d = wr_tgt;
        end else if (pre_hit) begin
          state_d = sbc_pkg::SBC_PRECHG;
        end else if (bad_cmd) begin
          illegal_d = 1'b1;
        end
      end
      sbc_pkg::SBC_READ, sbc_pkg::SBC_WRITE: begin
        if (rd_hit) begin
          state_d = rd_tgt;
        end else if (wr_hit) begin
          state_d = wr_tgt;
        end else if (is_bst || rw_miss) begin
          state_d = sbc_pkg::SBC_ACTIVE;
        end else if (pre_hit) begin
          state_d = sbc_pkg::SBC_PRECHG;
        end else begin
          illegal_d = bad_cmd;
          if (en && ctr_last) begin
            state_d = (state_q == sbc_pkg::SBC_READ) ? sbc_pkg::SBC_ACTIVE :
                                                       sbc_pkg::SBC_WR_RECOV;
          end
        end
      end
      sbc_pkg::SBC_READ_AP, sbc_pkg::SBC_WRITE_AP: begin
        illegal_d = !quiet;
        if (en && ctr_last) begin
          state_d = (state_q == sbc_pkg::SBC_READ_AP) ? sbc_pkg::SBC_PRECHG :
                                                        sbc_pkg::SBC_WR_RECOV;
        end
      end
      sbc_pkg::SBC_WR_RECOV: begin
        if (!ap_q && rd_hit) begin
          state_d = rd_tgt;
        end else if (!ap_q && wr_hit) begin
          state_d = wr_tgt;
        end else if (!quiet && !is_bst && !rw_miss) begin
          illegal_d = 1'b1;
        end else if (timer_done) begin
          state_d = ap_q ? sbc_pkg::SBC_PRECHG : sbc_pkg::SBC_ACTIVE;
        end
      end
      sbc_pkg::SBC_PRECHG: begin
        if (rd_hit || wr_hit || bad_cmd) begin
          illegal_d = 1'b1;
        end else if (timer_done) begin
          state_d = sbc_pkg::SBC_IDLE;
        end
      end
      sbc_pkg::SBC_PDOWN: begin
        if (cke_now) begin
          state_d = sbc_pkg::SBC_IDLE;
        end
      end
      default: begin
        state_d = sbc_pkg::SBC_IDLE;
      end
    endcase
  end

  // two-flop synchroniser for every pin
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pin_s1_q   <= `SBC_PIN_RST;
      pin_s2_q   <= `SBC_PIN_RST;
      cke_prev_q <= 1'b0;
    end else begin
      pin_s1_q   <= pin_raw;
      pin_s2_q   <= pin_s1_q;
      cke_prev_q <= pin_s2_q[`SBC_PIN_CKE];
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= sbc_pkg::SBC_IDLE;
      ap_q    <= 1'b0;
      timer_q <= 8'h00;
    end else begin
      state_q <= state_d;
      if (state_q != sbc_pkg::SBC_WR_RECOV) begin
        ap_q <= (state_q == sbc_pkg::SBC_WRITE_AP);
      end
      if (pre_entry) begin
        timer_q <= 8'(`SBC_T_RP_CYC - 1);
      end else if ((state_d == sbc_pkg::SBC_WR_RECOV) && (state_q != state_d)) begin
        timer_q <= 8'(`SBC_T_WR_CYC - 1);
      end else if (!timer_done) begin
        timer_q <= timer_q - 8'h01;
      end
    end
  end

  // read data drains through the latency pipe
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rd_pipe_q  <= 2'h0;
      rd_valid_o <= 1'b0;
    end else if (en) begin
      rd_pipe_q  <= {rd_pipe_q[0], rd_beat};
      rd_valid_o <= cas_lat3_i ? rd_pipe_q[1] : rd_pipe_q[0];
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wr_accept_o  <= 1'b0;
      precharge_o  <= 1'b0;
      refresh_o    <= 1'b0;
      mode_write_o <= 1'b0;
      illegal_o    <= 1'b0;
    end else begin
      wr_accept_o  <= en && ctr_active && in_wr;
      precharge_o  <= pre_entry;
      refresh_o    <= (state_q == sbc_pkg::SBC_IDLE) && is_ref;
      mode_write_o <= (state_q == sbc_pkg::SBC_IDLE) && is_mrs;
      illegal_o    <= illegal_d;
    end
  end

  assign state_o = state_q;

  // burst counter stops whenever the burst state is left
  sbc_burst_ctr u_ctr (
    .clk_sys_i  (clk_sys_i),
    .rst_i      (rst_i),
    .en_i       (en),
    .load_i     (ctr_load),
    .stop_i     (!burst_nx),
    .col_i      (addr[`SBC_COL_W-1:0]),
    .len_code_i (burst_len_i),
    .active_o   (ctr_active),
    .last_o     (ctr_last),
    .col_o      (col_o)
  );

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  a_idle_quiet_stay: assert property (
    (state_q == sbc_pkg::SBC_IDLE) && cke_now && (quiet || is_bst) |=>
      (state_q == sbc_pkg::SBC_IDLE) && !illegal_o)
    else $error("idle left on a quiet command");
  a_read_natural_end: assert property (
    (state_q == sbc_pkg::SBC_READ) && en && ctr_last && quiet |=>
      state_q == sbc_pkg::SBC_ACTIVE)
    else $error("read burst end did not return to row active");
  a_read_bst_end: assert property (
    (state_q == sbc_pkg::SBC_READ) && is_bst |=>
      (state_q == sbc_pkg::SBC_ACTIVE) && !ctr_active)
    else $error("burst stop did not end read");
  a_read_restart: assert property (
    (state_q == sbc_pkg::SBC_READ) && rd_hit |=>
      in_rd && ctr_active && (col_o == $past(addr[`SBC_COL_W-1:0])))
    else $error("read did not restart at new column");
  a_read_to_write: assert property (
    (state_q == sbc_pkg::SBC_READ) && wr_hit |=> in_wr ##1 wr_accept_o || !$past(en))
    else $error("write did not interrupt read");
  a_read_precharge: assert property (
    (state_q == sbc_pkg::SBC_READ) && pre_hit |=>
      (state_q == sbc_pkg::SBC_PRECHG) && precharge_o)
    else $error("precharge did not end read");
  a_write_natural_end: assert property (
    (state_q == sbc_pkg::SBC_WRITE) && en && ctr_last && quiet |=>
      state_q == sbc_pkg::SBC_WR_RECOV)
    else $error("write burst end did not enter recovery");
  a_write_bst_end: assert property (
    (state_q == sbc_pkg::SBC_WRITE) && is_bst |=>
      (state_q == sbc_pkg::SBC_ACTIVE) ##1 !wr_accept_o)
    else $error("burst stop did not end write");
  a_write_to_read: assert property (
    (state_q == sbc_pkg::SBC_WRITE) && rd_hit |=>
      in_rd && (col_o == $past(addr[`SBC_COL_W-1:0])))
    else $error("read did not interrupt write");
  a_write_restart: assert property (
    (state_q == sbc_pkg::SBC_WRITE) && wr_hit |=>
      in_wr && (col_o == $past(addr[`SBC_COL_W-1:0])))
    else $error("write did not restart at new column");
  a_write_precharge: assert property (
    (state_q == sbc_pkg::SBC_WRITE) && pre_hit |=>
      (state_q == sbc_pkg::SBC_PRECHG) && precharge_o)
    else $error("precharge did not end write");
  a_autopre_guard: assert property (
    (state_q == sbc_pkg::SBC_READ_AP) && !quiet && !ctr_last |=>
      illegal_o && (state_q == $past(state_q)))
    else $error("forbidden command changed auto-precharge read");
  a_active_illegal: assert property (
    (state_q == sbc_pkg::SBC_ACTIVE) && bad_cmd |=>
      (state_q == sbc_pkg::SBC_ACTIVE) && illegal_o)
    else $error("illegal command altered row active");
  a_bst_drain_cl3: assert property (
    (state_q == sbc_pkg::SBC_READ) && is_bst && rd_beat && cas_lat3_i ##1 en [*2] |=>
      rd_valid_o)
    else $error("read data stopped before cas latency");
  a_bst_drain_done: assert property (
    (state_q == sbc_pkg::SBC_READ) && is_bst && rd_beat ##1 en [*3] |=> !rd_valid_o)
    else $error("read data continued past cas latency");
  a_pdown_hold: assert property (
    (state_q == sbc_pkg::SBC_PDOWN) && !cke_now |=>
      (state_q == sbc_pkg::SBC_PDOWN) && !illegal_o && !refresh_o)
    else $error("power-down left while cke low");
  a_bst_kills_burst: assert property (
    (in_rd || in_wr) && is_bst && (state_q != sbc_pkg::SBC_READ_AP) &&
      (state_q != sbc_pkg::SBC_WRITE_AP) |=> !ctr_active)
    else $error("burst stop left burst running");

  c_read_full: cover property (
    (state_q == sbc_pkg::SBC_READ) && ctr_last && quiet ##1 state_q == sbc_pkg::SBC_ACTIVE);
  c_read_to_write: cover property ((state_q == sbc_pkg::SBC_READ) && wr_hit);
  c_autopre_done: cover property (
    (state_q == sbc_pkg::SBC_READ_AP) ##1 state_q == sbc_pkg::SBC_PRECHG);
  c_pdown_cycle: cover property (
    (state_q == sbc_pkg::SBC_PDOWN) ##1 state_q == sbc_pkg::SBC_IDLE);
endmodule

// >>> verification/sbc_ctl_model.sv
// controller model issuing commands to one bank state machine
`timescale 1ns/1ps
`include "sbc_params.svh"
module sbc_ctl_model (
  input  wire logic                   clk_sys_i,
  input  sbc_pkg::sbc_state_e         state_i,
  input  wire logic                   allow_bad_i,
  output logic                        cke_o,
  output logic                        cs_n_o,
  output logic                        ras_n_o,
  output logic                        cas_n_o,
  output logic                        we_n_o,
  output logic [`SBC_ADDR_W-1:0]      addr_o
);
  initial begin
    cke_o = 1'b1;
    cs_n_o = 1'b1;
    ras_n_o = 1'b1;
    cas_n_o = 1'b1;
    we_n_o = 1'b1;
    addr_o = '0;
  end

  // deselect with don't-care pins toggling every cycle
  task automatic drop;
    cs_n_o <= 1'b1;
    ras_n_o <= ~ras_n_o;
    cas_n_o <= ~cas_n_o;
    we_n_o <= ~we_n_o;
    addr_o <= ~addr_o;
  endtask

  task automatic issue(input sbc_pkg::sbc_cmd_t cmd, input logic [`SBC_ADDR_W-1:0] a);
    sbc_pkg::sbc_cmd_t c;
    logic burst;
    logic bad;
    @(posedge clk_sys_i);
    c = cmd;
    burst = state_i inside {sbc_pkg::SBC_READ, sbc_pkg::SBC_WRITE, sbc_pkg::SBC_WRITE_AP};
    bad = (burst && (c == `SBC_CMD_ACT || c == `SBC_CMD_REF || c == `SBC_CMD_MRS)) ||
          (state_i == sbc_pkg::SBC_IDLE && (c == `SBC_CMD_READ || c == `SBC_CMD_WRITE));
    bad = bad || (state_i == sbc_pkg::SBC_READ_AP && c != `SBC_CMD_NOP);
    if (bad && !allow_bad_i) begin
      c = `SBC_CMD_NOP;
    end
    cs_n_o <= 1'b0;
    {ras_n_o, cas_n_o, we_n_o} <= c;
    addr_o <= a;
    @(posedge clk_sys_i);
    drop();
  endtask

  task automatic quiet(input int n, input logic nop);
    repeat (n) begin
      @(posedge clk_sys_i);
      if (nop) begin
        cs_n_o <= 1'b0;
        {ras_n_o, cas_n_o, we_n_o} <= `SBC_CMD_NOP;
        addr_o <= ~addr_o;
      end else begin
        drop();
      end
    end
  endtask

  task automatic set_cke(input logic v);
    @(posedge clk_sys_i);
    cke_o <= v;
  endtask
endmodule

// >>> verification/sbc_bank_fsm_bench.sv
// self-checking bench for the bank command state machine
`timescale 1ns/1ps
`include "sbc_params.svh"
module sbc_bank_fsm_bench;
  localparam int LIMIT = 6000;
  logic                   clk_sys_i = 1'b0;
  logic                   rst_i = 1'b1;
  logic [2:0]             burst_len = `SBC_BL_8;
  logic                   cas_lat3 = 1'b0;
  logic                   allow_bad = 1'b0;
  logic                   cke, cs_n, ras_n, cas_n, we_n;
  logic [`SBC_ADDR_W-1:0] addr;
  sbc_pkg::sbc_state_e    state;
  logic [`SBC_COL_W-1:0]  col;
  logic                   rd_v, wr_a, pre_p, ref_p, mw_p, ill_p;
  int                     error_cnt = 0;
  int                     tests_run = 0;
  int                     cyc = 0;
  int                     rd_cnt, wr_cnt, pre_cnt, ref_cnt, mw_cnt, ill_cnt;

  always #2 clk_sys_i = ~clk_sys_i;

  sbc_bank_fsm #(.BANK_INDEX(1'h0)) uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .cke_i(cke),
    .cs_n_i(cs_n), .ras_n_i(ras_n), .cas_n_i(cas_n), .we_n_i(we_n), .addr_i(addr),
    .burst_len_i(burst_len), .cas_lat3_i(cas_lat3), .state_o(state), .col_o(col),
    .rd_valid_o(rd_v), .wr_accept_o(wr_a), .precharge_o(pre_p), .refresh_o(ref_p),
    .mode_write_o(mw_p), .illegal_o(ill_p));

  sbc_ctl_model ctl (.clk_sys_i(clk_sys_i), .state_i(state), .allow_bad_i(allow_bad),
    .cke_o(cke), .cs_n_o(cs_n), .ras_n_o(ras_n), .cas_n_o(cas_n), .we_n_o(we_n),
    .addr_o(addr));

  task automatic finish_test;
    $display("checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic fail(input string m);
    error_cnt++;
    $display("ERROR %0t: %s", $time, m);
  endtask

  always @(posedge clk_sys_i) begin
    cyc++;
    if (rd_v === 1'b1) rd_cnt++;
    if (wr_a === 1'b1) wr_cnt++;
    if (pre_p === 1'b1) pre_cnt++;
    if (ref_p === 1'b1) ref_cnt++;
    if (mw_p === 1'b1) mw_cnt++;
    if (ill_p === 1'b1) ill_cnt++;
    if (cyc == LIMIT) begin
      fail("run too long");
      finish_test();
    end
  end

  function automatic logic [`SBC_ADDR_W-1:0] ad(input logic ap, input logic [7:0] c);
    return {1'b0, ap, c};
  endfunction

  task automatic clr;
    {rd_cnt, wr_cnt, pre_cnt, ref_cnt, mw_cnt, ill_cnt} = '0;
  endtask

  task automatic check_st(input sbc_pkg::sbc_state_e e);
    tests_run++;
    if (state !== e) fail($sformatf("state %h expected %h", state, e));
  endtask

  task automatic check_col(input logic [7:0] e);
    tests_run++;
    if (col !== e) fail($sformatf("column %h expected %h", col, e));
  endtask

  task automatic check_n(input int got, input int lo, input int hi, input string m);
    tests_run++;
    if (got < lo || got > hi) fail($sformatf("%s count %0d", m, got));
  endtask

  task automatic wait_st(input sbc_pkg::sbc_state_e e);
    int i;
    i = 0;
    @(negedge clk_sys_i);
    while (state !== e && i < 40) begin
      @(negedge clk_sys_i);
      i++;
    end
    check_st(e);
  endtask

  task automatic wait_col(input logic [7:0] e);
    int i;
    i = 0;
    while (col !== e && i < 12) begin
      @(negedge clk_sys_i);
      i++;
    end
    check_col(e);
  endtask

  task automatic t_idle;
    clr();
    ctl.quiet(3, 1'b0);
    ctl.quiet(3, 1'b1);
    ctl.issue(`SBC_CMD_BST, ad(1'b0, 8'h00));
    ctl.issue(`SBC_CMD_PRE, ad(1'b0, 8'h00));
    ctl.issue(`SBC_CMD_REF, ad(1'b0, 8'h00));
    ctl.issue(`SBC_CMD_MRS, ad(1'b0, 8'h22));
    ctl.quiet(6, 1'b1);
    check_st(sbc_pkg::SBC_IDLE);
    check_n(ill_cnt, 0, 0, "illegal");
    check_n(ref_cnt + mw_cnt, 2, 2, "refresh and mode");
    ctl.set_cke(1'b0);
    wait_st(sbc_pkg::SBC_PDOWN);
    ctl.issue(`SBC_CMD_ACT, ad(1'b0, 8'h00));
    ctl.quiet(3, 1'b1);
    ctl.set_cke(1'b1);
    wait_st(sbc_pkg::SBC_IDLE);
    ctl.quiet(6, 1'b1);
    check_st(sbc_pkg::SBC_IDLE);
    $display("test idle and power-down done");
  endtask

  task automatic t_active;
    sbc_pkg::sbc_cmd_t bad_cmds [3] = '{`SBC_CMD_ACT, `SBC_CMD_REF, `SBC_CMD_MRS};
    ctl.issue(`SBC_CMD_ACT, ad(1'b0, 8'h00));
    wait_st(sbc_pkg::SBC_ACTIVE);
    foreach (bad_cmds[i]) begin
      clr();
      ctl.issue(bad_cmds[i], ad(1'b0, 8'h00));
      ctl.quiet(5, 1'b1);
      check_n(ill_cnt, 1, 1, "illegal");
      check_st(sbc_pkg::SBC_ACTIVE);
    end
    $display("test row active done");
  endtask

  task automatic t_read;
    clr();
    ctl.issue(`SBC_CMD_READ, ad(1'b0, 8'h05));
    wait_st(sbc_pkg::SBC_READ);
    check_col(8'h05);
    wait_st(sbc_pkg::SBC_ACTIVE);
    ctl.quiet(5, 1'b0);
    check_n(rd_cnt, 8, 8, "read beats");
    clr();
    ctl.issue(`SBC_CMD_READ, ad(1'b0, 8'h00));
    ctl.issue(`SBC_CMD_BST, ad(1'b0, 8'h00));
    wait_st(sbc_pkg::SBC_ACTIVE);
    ctl.quiet(6, 1'b1);
    check_n(rd_cnt, 2, 2, "stopped read beats");
    check_st(sbc_pkg::SBC_ACTIVE);
    ctl.issue(`SBC_CMD_READ, ad(1'b0, 8'h05));
    ctl.issue(`SBC_CMD_READ, ad(1'b0, 8'h20));
    wait_col(8'h20);
    check_st(sbc_pkg::SBC_READ);
    wait_st(sbc_pkg::SBC_ACTIVE);
    ctl.issue(`SBC_CMD_READ, ad(1'b0, 8'h00));
    ctl.issue(`SBC_CMD_WRITE, ad(1'b0, 8'h40));
    wait_st(sbc_pkg::SBC_WRITE);
    check_col(8'h40);
    wait_st(sbc_pkg::SBC_WR_RECOV);
    wait_st(sbc_pkg::SBC_ACTIVE);
    $display("test read bursts done");
  endtask

  task automatic t_write;
    clr();
    ctl.issue(`SBC_CMD_WRITE, ad(1'b0, 8'h10));
    wait_st(sbc_pkg::SBC_WRITE);
    wait_st(sbc_pkg::SBC_WR_RECOV);
    wait_st(sbc_pkg::SBC_ACTIVE);
    check_n(wr_cnt, 8, 8, "write beats");
    clr();
    ctl.issue(`SBC_CMD_WRITE, ad(1'b0, 8'h00));
    ctl.issue(`SBC_CMD_BST, ad(1'b0, 8'h00));
    wait_st(sbc_pkg::SBC_ACTIVE);
    ctl.quiet(6, 1'b1);
    check_n(wr_cnt, 2, 2, "stopped write beats");
    check_st(sbc_pkg::SBC_ACTIVE);
    ctl.issue(`SBC_CMD_WRITE, ad(1'b0, 8'h00));
    ctl.issue(`SBC_CMD_READ, ad(1'b0, 8'h30));
    wait_st(sbc_pkg::SBC_READ);
    check_col(8'h30);
    wait_st(sbc_pkg::SBC_ACTIVE);
    ctl.issue(`SBC_CMD_WRITE, ad(1'b0, 8'h00));
    ctl.issue(`SBC_CMD_WRITE, ad(1'b0, 8'h50));
    wait_col(8'h50);
    check_st(sbc_pkg::SBC_WRITE);
    wait_st(sbc_pkg::SBC_WR_RECOV);
    wait_st(sbc_pkg::SBC_ACTIVE);
    $display("test write bursts done");
  endtask

  task automatic t_precharge;
    clr();
    ctl.issue(`SBC_CMD_READ, ad(1'b0, 8'h00));
    ctl.issue(`SBC_CMD_PRE, ad(1'b0, 8'h00));
    wait_st(sbc_pkg::SBC_PRECHG);
    wait_st(sbc_pkg::SBC_IDLE);
    check_n(pre_cnt, 1, 1, "precharge");
    ctl.issue(`SBC_CMD_ACT, ad(1'b0, 8'h00));
    wait_st(sbc_pkg::SBC_ACTIVE);
    ctl.issue(`SBC_CMD_WRITE, ad(1'b0, 8'h00));
    ctl.issue(`SBC_CMD_PRE, ad(1'b1, 8'h00));
    wait_st(sbc_pkg::SBC_PRECHG);
    wait_st(sbc_pkg::SBC_IDLE);
    check_n(pre_cnt, 2, 2, "precharge");
    $display("test precharge done");
  endtask

  task automatic t_read_ap;
    ctl.issue(`SBC_CMD_ACT, ad(1'b0, 8'h00));
    wait_st(sbc_pkg::SBC_ACTIVE);
    clr();
    allow_bad = 1'b1;
    ctl.issue(`SBC_CMD_READ, ad(1'b1, 8'h00));
    wait_st(sbc_pkg::SBC_READ_AP);
    ctl.issue(`SBC_CMD_BST, ad(1'b0, 8'h00));
    wait_st(sbc_pkg::SBC_PRECHG);
    wait_st(sbc_pkg::SBC_IDLE);
    allow_bad = 1'b0;
    check_n(ill_cnt, 1, 1, "illegal");
    check_n(rd_cnt, 8, 8, "read beats");
    $display("test auto-precharge read done");
  endtask

  task automatic t_lengths;
    logic [2:0] codes [4] = '{`SBC_BL_1, `SBC_BL_2, `SBC_BL_4, `SBC_BL_PAGE};
    int         beats [4] = '{1, 2, 4, 256};
    logic [7:0] wrap [3] = '{8'h06, 8'h07, 8'h04};
    ctl.issue(`SBC_CMD_ACT, ad(1'b0, 8'h00));
    wait_st(sbc_pkg::SBC_ACTIVE);
    @(posedge clk_sys_i);
    cas_lat3 <= 1'b1;
    foreach (codes[i]) begin
      burst_len <= codes[i];
      clr();
      ctl.issue(`SBC_CMD_READ, ad(1'b0, 8'h05));
      ctl.quiet(beats[i] + 8, 1'b1);
      check_n(rd_cnt, beats[i], beats[i], "read beats");
      check_st(sbc_pkg::SBC_ACTIVE);
    end
    burst_len <= `SBC_BL_4;
    ctl.issue(`SBC_CMD_READ, ad(1'b0, 8'h05));
    wait_st(sbc_pkg::SBC_READ);
    foreach (wrap[i]) begin
      @(negedge clk_sys_i);
      check_col(wrap[i]);
    end
    wait_st(sbc_pkg::SBC_ACTIVE);
    ctl.quiet(5, 1'b1);
    clr();
    ctl.issue(`SBC_CMD_READ, ad(1'b0, 8'h00));
    ctl.issue(`SBC_CMD_BST, ad(1'b0, 8'h00));
    wait_st(sbc_pkg::SBC_ACTIVE);
    ctl.quiet(6, 1'b1);
    check_n(rd_cnt, 2, 2, "latency 3 stopped read beats");
    clr();
    ctl.issue(`SBC_CMD_WRITE, ad(1'b1, 8'h00));
    wait_st(sbc_pkg::SBC_WRITE_AP);
    wait_st(sbc_pkg::SBC_WR_RECOV);
    wait_st(sbc_pkg::SBC_IDLE);
    check_n(wr_cnt, 4, 4, "auto-precharge write beats");
    check_n(pre_cnt, 1, 1, "auto-precharge write precharge");
    $display("test burst lengths and latency 3 done");
  endtask

  initial begin
    repeat (20) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    t_idle();
    t_active();
    t_read();
    t_write();
    t_precharge();
    t_read_ap();
    t_lengths();
    finish_test();
  end
endmodule
